// File: logic/pll_divider_lock_control.sv
// Divider chain, feedback choice, skew lines and lock detector.
// Assumes clock-like inputs are sampled levels synchronous to core_clk_i.
// Notes on behaviour
// - Lock output is low while locked, high otherwise.
// - Lock criterion selectable: phase match or frequency match.
// - Phase mode asserts lock at once on a match.
// - Frequency mode needs 16 or 256 matching comparator cycles first.
// - Loss of lock deasserts the output at once in both modes.
// - Input prescaler divides the chosen reference by 1 to 40.
// - Feedback prescaler divides the feedback clock by 1 to 40.
// - Five output stages, each an even ratio 2 to 80.
// - Any one output stage may close the feedback path.
// - Locked output rate is ref times N times Vfbk over M times Vk.
// - Option bypasses both prescalers for glitch-free clock switching.
// - Loop bypass feeds prescaler output straight into output stages.
// - Loop bypass halves each stage ratio, 1 to 40.
// - Loop bypass gives no lock detection and no skew.
// - Skew delays count oscillator periods.
// - Pair choice 0 selects first pair, 1 the second.
// - Logic reset of at least 20 ns clears only digital state.
`timescale 1ns/1ps

`include "pll_params.svh"

module pll_divider_lock_control
  import pll_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire pll_cfg_t           cfg_i,
  input  wire logic               ref_a_i,
  input  wire logic               ref_b_i,
  input  wire logic               fbk_a_i,
  input  wire logic               fbk_b_i,
  input  wire logic               reference_pair_choice_i,
  input  wire logic               feedback_pair_choice_i,
  input  wire logic               osc_i,
  input  wire logic               loop_bypass_i,
  output logic                    presc_ref_o,
  output logic                    presc_fbk_o,
  output logic [`STAGES-1:0]      clk_out_o,
  output logic                    fbk_stage_o,
  output logic                    lock_n_o
);

  // ****************************************************************
  // Source edge detection
  // ****************************************************************
  logic ref_lvl, fbk_lvl;
  logic ref_prev_q, fbk_prev_q, osc_prev_q;
  logic ref_edge, fbk_edge, osc_edge;

  assign ref_lvl  = reference_pair_choice_i ? ref_b_i : ref_a_i;
  assign fbk_lvl  = feedback_pair_choice_i ? fbk_b_i : fbk_a_i;
  assign ref_edge = ref_lvl & ~ref_prev_q;
  assign fbk_edge = fbk_lvl & ~fbk_prev_q;
  assign osc_edge = osc_i & ~osc_prev_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_prev_q <= 1'b0;
      fbk_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_lvl;
      fbk_prev_q <= fbk_lvl;
      osc_prev_q <= osc_i;
    end
  end

  // ****************************************************************
  // Ratio clamping
  // ****************************************************************
  function automatic ratio_t clamp_pre(input ratio_t r);
    if (r < `PRE_MIN)      clamp_pre = `PRE_MIN;
    else if (r > `PRE_MAX) clamp_pre = `PRE_MAX;
    else                   clamp_pre = r;
  endfunction : clamp_pre

  function automatic ratio_t clamp_out(input ratio_t r, input logic byp);
    ratio_t e;
    e = {r[6:1], 1'b0};
    if (e < `OUT_MIN)      e = `OUT_MIN;
    else if (e > `OUT_MAX) e = `OUT_MAX;
    clamp_out = byp ? 7'(e >> 1) : e;
  endfunction : clamp_out

  // ****************************************************************
  // Prescalers
  // ****************************************************************
  ratio_t m_eff, n_eff;
  logic   m_pulse, n_pulse;

  // Bypass forces ratio one so the switch follows the source edge
  assign m_eff = cfg_i.presc_bypass ? `PRE_MIN : clamp_pre(cfg_i.m_ratio);
  assign n_eff = cfg_i.presc_bypass ? `PRE_MIN : clamp_pre(cfg_i.n_ratio);

  ratio_divider u_m_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (ref_edge),
    .ratio_i    (m_eff),
    .pulse_o    (m_pulse),
    .level_o    (presc_ref_o)
  );

  ratio_divider u_n_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (fbk_edge),
    .ratio_i    (n_eff),
    .pulse_o    (n_pulse),
    .level_o    (presc_fbk_o)
  );

  // ****************************************************************
  // Output stages with skew lines
  // ****************************************************************
  logic                  v_tick;
  logic [`STAGES-1:0]    v_level;
  ratio_t [`STAGES-1:0]  v_eff;
  logic [`STAGES-1:0]    out_d;

  assign v_tick = loop_bypass_i ? m_pulse : osc_edge;

  genvar k;
  generate
    for (k = 0; k < `STAGES; k++) begin : g_stage
      logic [`SKEW_DEPTH-1:0] sk_q, sk_d;

      assign v_eff[k] = clamp_out(cfg_i.v_ratio[k], loop_bypass_i);

      ratio_divider u_v_div (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (v_tick),
        .ratio_i    (v_eff[k]),
        .pulse_o    (),
        .level_o    (v_level[k])
      );

      // Delay taps advance per oscillator period, not per core cycle
      always_comb begin
        sk_d = sk_q;
        if (osc_edge)
          sk_d = {sk_q[`SKEW_DEPTH-2:0], v_level[k]};
        if (loop_bypass_i || cfg_i.v_skew[k] == 4'h0)
          out_d[k] = v_level[k];
        else
          out_d[k] = sk_q[4'(cfg_i.v_skew[k] - 4'h1)];
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) sk_q <= '0;
        else       sk_q <= sk_d;
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_out_o   <= '0;
      fbk_stage_o <= 1'b0;
    end else begin
      clk_out_o   <= out_d;
      // Out-of-range choice falls back to the last stage
      fbk_stage_o <= (cfg_i.fbk_stage < 3'(`STAGES)) ?
                     v_level[cfg_i.fbk_stage] : v_level[`STAGES-1];
    end
  end

  // ****************************************************************
  // Lock detector
  // ****************************************************************
  logic [3:0] since_fbk_q, since_fbk_d;
  logic [1:0] fbk_cnt_q, fbk_cnt_d;
  logic [8:0] qual_q, qual_d;
  logic [8:0] qual_target;
  logic       locked_q, locked_d;
  logic       phase_ok, freq_ok, match;

  assign qual_target = cfg_i.lock_long ? `QUAL_LONG : `QUAL_SHORT;
  assign phase_ok    = n_pulse || (since_fbk_q <= `PHASE_WIN_CYC);
  assign freq_ok     = (fbk_cnt_q + {1'b0, n_pulse}) == 2'h1;
  assign match       = (cfg_i.lock_mode == LOCK_FREQ) ? freq_ok
                                                      : phase_ok;

  always_comb begin
    since_fbk_d = n_pulse ? 4'h0 :
                  (since_fbk_q == 4'hF ? 4'hF : 4'(since_fbk_q + 4'h1));
    fbk_cnt_d   = m_pulse ? 2'h0 :
                  (fbk_cnt_q == 2'h3 ? 2'h3 :
                   2'(fbk_cnt_q + {1'b0, n_pulse}));
    qual_d      = qual_q;
    locked_d    = locked_q;
    if (loop_bypass_i) begin
      qual_d   = 9'h000;
      locked_d = 1'b0;
    end else if (m_pulse) begin
      if (!match) begin
        qual_d   = 9'h000;
        locked_d = 1'b0;
      end else if (cfg_i.lock_mode == LOCK_PHASE) begin
        locked_d = 1'b1;
      end else if (!locked_q) begin
        qual_d   = 9'(qual_q + 9'h001);
        locked_d = (9'(qual_q + 9'h001) >= qual_target);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_fbk_q <= 4'hF;
      fbk_cnt_q   <= 2'h0;
      qual_q      <= 9'h000;
      locked_q    <= 1'b0;
    end else begin
      since_fbk_q <= since_fbk_d;
      fbk_cnt_q   <= fbk_cnt_d;
      qual_q      <= qual_d;
      locked_q    <= locked_d;
    end
  end

  assign lock_n_o = ~locked_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  bypass_no_lock_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    loop_bypass_i |=> lock_n_o && qual_q == 9'h000)
    else $error("lock shown during loop bypass");

  phase_fast_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    m_pulse && match && !loop_bypass_i && cfg_i.lock_mode == LOCK_PHASE
    |=> !lock_n_o)
    else $error("phase match did not lock at once");

  loss_fast_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    m_pulse && !match |=> lock_n_o)
    else $error("lock not dropped at once");

  freq_count_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(lock_n_o) && cfg_i.lock_mode == LOCK_FREQ && $stable(cfg_i)
    |-> qual_q == qual_target)
    else $error("frequency lock without full qualification");

  presc_bypass_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cfg_i.presc_bypass && ref_edge && $stable(cfg_i) |=> m_pulse)
    else $error("bypassed prescaler did not follow edge");

  fbk_route_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cfg_i.fbk_stage == 3'h0 ##1 cfg_i.fbk_stage == 3'h0
    |-> fbk_stage_o == $past(v_level[0]))
    else $error("feedback stage not routed");

  even_ratio_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !loop_bypass_i |-> v_eff[1][0] == 1'b0 && v_eff[1] >= `OUT_MIN)
    else $error("output stage ratio not even");

  // Ratio four must halve to two; stage four runs at that setting
  bypass_half_a : assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    loop_bypass_i && cfg_i.v_ratio[4] == 7'h04 |-> v_eff[4] == 7'h02)
    else $error("bypass ratio not halved");

endmodule : pll_divider_lock_control

// File: logic/pll_params.svh
// Offsets-free constant set for the divider and lock control block.
// Assumes inclusion by bare name from files that need the figures.
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH

// ****************************************************************
// Clock and reset timing
// ****************************************************************
`define CLK_PERIOD_PS   10000
`define RST_MIN_NS      20
`define RST_MIN_CYC     ((`RST_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ****************************************************************
// Divider ranges
// ****************************************************************
`define PRE_MIN         7'h01
`define PRE_MAX         7'h28
`define OUT_MIN         7'h02
`define OUT_MAX         7'h50
`define STAGES          5

// ****************************************************************
// Lock detector and skew line depth
// ****************************************************************
`define QUAL_SHORT      9'h010
`define QUAL_LONG       9'h100
`define PHASE_WIN_CYC   4'h2
`define SKEW_DEPTH      16

`endif

// File: logic/pll_pkg.sv
// Types shared by the divider and lock control block.
// Assumes the constants header is available on the include path.
`include "pll_params.svh"

package pll_pkg;

  // ****************************************************************
  // Modes and configuration carrier
  // ****************************************************************
  typedef enum logic {
    LOCK_PHASE,
    LOCK_FREQ
  } lock_mode_t;

  typedef logic [6:0] ratio_t;
  typedef logic [3:0] skew_t;

  typedef struct packed {
    ratio_t                     m_ratio;
    ratio_t                     n_ratio;
    ratio_t [`STAGES-1:0]       v_ratio;
    skew_t  [`STAGES-1:0]       v_skew;
    logic   [2:0]               fbk_stage;
    lock_mode_t                 lock_mode;
    logic                       lock_long;
    logic                       presc_bypass;
  } pll_cfg_t;

endpackage : pll_pkg

// File: logic/ratio_divider.sv
// Integer ratio divider driven by one-cycle source ticks.
// Assumes ratio_i is already within range and at least one.
`timescale 1ns/1ps

module ratio_divider
  import pll_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   rst_i,
  input  wire logic   tick_i,
  input  wire ratio_t ratio_i,
  output logic        pulse_o,
  output logic        level_o
);

  ratio_t cnt_q;
  ratio_t cnt_d;
  logic   pulse_d;
  logic   level_d;
  ratio_t half;

  // ****************************************************************
  // Counting
  // ****************************************************************
  always_comb begin
    half    = 7'((ratio_i + 7'h01) >> 1);
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    level_d = level_o;
    if (tick_i) begin
      if (cnt_q >= 7'(ratio_i - 7'h01)) begin
        cnt_d   = 7'h00;
        pulse_d = 1'b1;
      end else begin
        cnt_d = 7'(cnt_q + 7'h01);
      end
      // Ratio one keeps the level high; pulses carry the rate
      level_d = (cnt_d < half);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= 7'h00;
      pulse_o <= 1'b0;
      level_o <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_o <= pulse_d;
      level_o <= level_d;
    end
  end

endmodule : ratio_divider

// File: verif/ref_fbk_source.sv
// Reference pair, feedback pair and oscillator levels for the bench.
// Assumes a free-running core clock; stopped lines idle low.
`timescale 1ns/1ps

module ref_fbk_source (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] half_i,
  input  wire logic [1:0] ref_en_i,
  input  wire logic [1:0] fbk_en_i,
  input  wire logic       osc_en_i,
  output logic            ref_a_o,
  output logic            ref_b_o,
  output logic            fbk_a_o,
  output logic            fbk_b_o,
  output logic            osc_o
);
  // ********************
  // Square waves
  // ********************
  logic [7:0] cnt_q  = 8'h00;
  logic       wave_q = 1'b0;
  logic       osc_q  = 1'b0;

  // Half period of one cycle or more keeps a low sample between edges
  always @(posedge core_clk_i) begin
    osc_q <= osc_en_i & ~osc_q;
    if (cnt_q + 8'h01 >= half_i) begin
      cnt_q  <= 8'h00;
      wave_q <= ~wave_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Feedback in phase with reference, as a settled external path
  assign ref_a_o = wave_q & ref_en_i[0];
  assign ref_b_o = wave_q & ref_en_i[1];
  assign fbk_a_o = wave_q & fbk_en_i[0];
  assign fbk_b_o = wave_q & fbk_en_i[1];
  assign osc_o   = osc_q;
endmodule : ref_fbk_source

// File: verif/tb_pll_divider_lock_control.sv
// Self-checking bench for the divider and lock control block.
// Assumes the package and the source model are compiled before it.
`timescale 1ns/1ps

module tb_pll_divider_lock_control import pll_pkg::*;;
  // ********************
  // Stimulus and tallies
  // ********************
  logic       core_clk_i;
  logic       rst_i;
  logic       clr;
  logic       ref_sel;
  logic       fbk_sel;
  logic       loop_byp;
  logic       osc_en;
  logic       ref_a, ref_b, fbk_a, fbk_b, osc;
  logic       presc_ref, presc_fbk, fstage, lock_n;
  logic [4:0] clk_out;
  logic [7:0] half;
  logic [1:0] ref_en;
  logic [1:0] fbk_en;
  logic [8:0] cur;
  logic [8:0] prev_q;
  pll_cfg_t   cfg;
  int         fails = 0;
  int         checks = 0;
  int         used;
  int         n_rise [9];

  ref_fbk_source src (.core_clk_i(core_clk_i), .half_i(half),
    .ref_en_i(ref_en), .fbk_en_i(fbk_en), .osc_en_i(osc_en),
    .ref_a_o(ref_a), .ref_b_o(ref_b), .fbk_a_o(fbk_a), .fbk_b_o(fbk_b),
    .osc_o(osc));

  pll_divider_lock_control DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cfg_i(cfg), .ref_a_i(ref_a), .ref_b_i(ref_b), .fbk_a_i(fbk_a),
    .fbk_b_i(fbk_b), .reference_pair_choice_i(ref_sel),
    .feedback_pair_choice_i(fbk_sel), .osc_i(osc),
    .loop_bypass_i(loop_byp), .presc_ref_o(presc_ref),
    .presc_fbk_o(presc_fbk), .clk_out_o(clk_out),
    .fbk_stage_o(fstage), .lock_n_o(lock_n));

  // Bits 0..4 stages, 5 feedback stage, 6..7 prescalers, 8 ref_a
  assign cur = {ref_a, presc_ref, presc_fbk, fstage, clk_out};
  always @(posedge core_clk_i) begin
    prev_q <= cur;
    for (int i = 0; i < 9; i++) begin
      n_rise[i] <= clr ? 0 : n_rise[i] + int'(cur[i] & ~prev_q[i]);
    end
  end

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic close_out();
    $display("Checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic cnt(string w, int lo, int hi, int g);
    checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask : cnt

  // Bounded wait on lock_n, judged at falling edges; ends on a rising edge
  task automatic wait_lock(logic lvl, int bound, output int n);
    n = 0;
    @(negedge core_clk_i);
    while (lock_n !== lvl) begin
      n++;
      if (n > bound) begin
        fails++;
        $display("Error lock_n expected %b seen %b", lvl, lock_n);
        close_out();
      end
      @(negedge core_clk_i);
    end
    @(posedge core_clk_i);
  endtask : wait_lock

  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i    <= 1'b1;
    clr      <= 1'b1;
    ref_en   <= 2'h0;
    fbk_en   <= 2'h0;
    osc_en   <= 1'b0;
    loop_byp <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    clr   <= 1'b0;
  endtask : do_reset

  // Own edge first, so a caller's last clr write is never overridden
  task automatic clear_counts();
    @(posedge core_clk_i);
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
  endtask : clear_counts

  // ********************
  // Scenarios
  // ********************
  task automatic sc_reset();
    do_reset();
    @(negedge core_clk_i);
    chk("lock_n", 8'h01, {7'h00, lock_n});
    chk("outputs", 8'h00, {presc_ref, presc_fbk, fstage, clk_out});
    @(posedge core_clk_i);
  endtask : sc_reset

  task automatic sc_phase();
    cfg.lock_mode <= LOCK_PHASE;
    do_reset();
    ref_en <= 2'h1;
    fbk_en <= 2'h1;
    wait_lock(1'b0, 60, used);
    cnt("phase lock delay", 0, 8, used);
    fbk_en <= 2'h0;
    wait_lock(1'b1, 60, used);
    cnt("phase loss delay", 0, 7, used);
  endtask : sc_phase

  task automatic sc_freq(logic lng, int q);
    cfg.lock_mode <= LOCK_FREQ;
    cfg.lock_long <= lng;
    do_reset();
    ref_en <= 2'h1;
    fbk_en <= 2'h1;
    wait_lock(1'b0, 1200, used);
    cnt("freq lock edges", q, q + 1, n_rise[8]);
    loop_byp <= 1'b1;
    wait_lock(1'b1, 20, used);
    cnt("bypass unlock", 0, 2, used);
    repeat (20) @(posedge core_clk_i);
    clear_counts();
    loop_byp <= 1'b0;
    wait_lock(1'b0, 1200, used);
    cnt("requalify edges", q - 1, q + 1, n_rise[8]);
    fbk_en <= 2'h0;
    wait_lock(1'b1, 60, used);
    cnt("freq loss delay", 0, 7, used);
  endtask : sc_freq

  task automatic sc_presc();
    cfg.m_ratio <= 7'h03;
    cfg.n_ratio <= 7'h02;
    ref_sel     <= 1'b1;
    fbk_sel     <= 1'b1;
    do_reset();
    ref_en <= 2'h2;
    fbk_en <= 2'h2;
    repeat (480) @(posedge core_clk_i);
    cnt("m prescaler", 39, 41, n_rise[7]);
    cnt("n prescaler", 59, 61, n_rise[6]);
    ref_sel <= 1'b0;
    fbk_sel <= 1'b0;
    clear_counts();
    repeat (100) @(posedge core_clk_i);
    cnt("unused pair", 0, 0, n_rise[7] + n_rise[6]);
  endtask : sc_presc

  task automatic sc_mn_bypass();
    cfg.lock_mode    <= LOCK_PHASE;
    cfg.presc_bypass <= 1'b1;
    half             <= 8'h03;
    do_reset();
    ref_en <= 2'h1;
    fbk_en <= 2'h1;
    wait_lock(1'b0, 60, used);
    cnt("bypass lock delay", 0, 10, used);
    used = 0;
    repeat (200) begin
      @(negedge core_clk_i);
      used += int'(lock_n !== 1'b0);
    end
    cnt("unlocked cycles", 0, 0, used);
    @(posedge core_clk_i);
    cfg.presc_bypass <= 1'b0;
    half             <= 8'h02;
  endtask : sc_mn_bypass

  // Both modes give 240 / V rises in 480 cycles for each stage
  task automatic sc_stages(logic byp);
    int f;
    cfg.m_ratio <= 7'h01;
    do_reset();
    osc_en   <= ~byp;
    ref_en   <= {1'b0, byp};
    loop_byp <= byp;
    for (int s = 0; s < (byp ? 1 : 6); s++) begin
      f = (s > 4) ? 4 : s;
      cfg.fbk_stage <= 3'((s == 5) ? 7 : s);
      clear_counts();
      repeat (480) @(posedge core_clk_i);
      for (int k = 0; k < 5; k++) begin
        used = 240 / (12 - 2 * k);
        cnt("stage rate", used - 1, used + 1, n_rise[k]);
      end
      used = 240 / (12 - 2 * f);
      if (!byp) cnt("feedback stage", used - 1, used + 1, n_rise[5]);
    end
  endtask : sc_stages

  initial begin
    rst_i    = 1'b1;
    clr      = 1'b1;
    ref_sel  = 1'b0;
    fbk_sel  = 1'b0;
    loop_byp = 1'b0;
    osc_en   = 1'b0;
    ref_en   = 2'h0;
    fbk_en   = 2'h0;
    half     = 8'h02;
    cfg      = '0;
    cfg.m_ratio = 7'h01;
    cfg.n_ratio = 7'h01;
    for (int k = 0; k < 5; k++) begin
      cfg.v_ratio[k] = 7'(12 - 2 * k);
      cfg.v_skew[k]  = 4'(k + 1);
    end
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_phase();
    sc_freq(1'b0, 16);
    sc_freq(1'b1, 256);
    sc_presc();
    sc_mn_bypass();
    sc_stages(1'b0);
    sc_stages(1'b1);
    close_out();
  end
endmodule : tb_pll_divider_lock_control
